/* File: include/micic_defs.svh */
// constants of the mcu interrupt controller
`ifndef MICIC_DEFS_SVH
`define MICIC_DEFS_SVH
`define MICIC_AW            13
`define MICIC_ADR_CTRL      13'h000b
`define MICIC_ADR_REQ0      13'h070c
`define MICIC_ADR_REQ1      13'h070d
`define MICIC_ADR_REQ2      13'h070e
`define MICIC_ADR_EN0       13'h0716
`define MICIC_ADR_EN1       13'h0717
`define MICIC_ADR_EN2       13'h0718
`define MICIC_ADR_SHD_BASE  13'h1f84
`define MICIC_SHD_N         8
`define MICIC_BIT_GIE       7
`define MICIC_BIT_PERIPHERAL_GROUP_ENABLE      6
`define MICIC_BIT_EDGE      0
`define MICIC_BIT_EXT       0
`define MICIC_BIT_IOC       4
`define MICIC_BIT_TMR0      5
`define MICIC_CTRL_RST      8'h01
`define MICIC_CTRL_MASK     8'hc1
`define MICIC_EN0_MASK      8'h31
`define MICIC_REQ0_WMASK    8'h21
`define MICIC_REQ1_WMASK    8'he7
`define MICIC_REQ2_WMASK    8'he0
`define MICIC_EN2_MASK      8'he0
`define MICIC_STATUS_KEEP   8'he7
`define MICIC_VECTOR        15'h0004
`endif

/* File: include/micic_pkg.sv */
// types of the mcu interrupt controller
package micic_pkg;
  typedef enum logic [0:0] {MICIC_RUN, MICIC_SKIP} micic_state_t;
  typedef logic [7:0] micic_byte_t;
endpackage : micic_pkg

/* File: design/micic_top.sv */
// mcu interrupt controller: flags, enables, vectoring, shadow context
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "micic_defs.svh"
module micic_top
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic [`MICIC_AW-1:0]  addr_in,
  input  wire logic [7:0]            wdata_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic      [7:0]            rdata_out,
  input  wire logic                  q1_in,
  input  wire logic                  ext_pin_in,
  input  wire logic                  timer0_ovf_in,
  input  wire logic [2:0]            per_port_change_flags_in,
  input  wire logic [7:0]            req1_set_in,
  input  wire logic [7:0]            req2_set_in,
  input  wire logic                  return_from_interrupt_in,
  input  wire logic                  sleeping_in,
  input  wire logic [7:0]            working_register_in,
  input  wire logic [7:0]            status_in,
  input  wire logic [7:0]            bank_select_register_in,
  input  wire logic [7:0]            fsr0_low_in,
  input  wire logic [7:0]            fsr0_high_in,
  input  wire logic [7:0]            fsr1_low_in,
  input  wire logic [7:0]            fsr1_high_in,
  input  wire logic [7:0]            pc_high_latch_in,
  output logic                       vector_out,
  output logic      [14:0]           vector_addr_out,
  output logic                       restore_out,
  output logic                       wake_out,
  output logic      [7:0]            working_register_out,
  output logic      [7:0]            status_out,
  output logic      [7:0]            bank_select_register_out,
  output logic      [7:0]            fsr0_low_out,
  output logic      [7:0]            fsr0_high_out,
  output logic      [7:0]            fsr1_low_out,
  output logic      [7:0]            fsr1_high_out,
  output logic      [7:0]            pc_high_latch_out
);

  // ==========================================================
  // functions
  // ==========================================================
  // flag update: hardware set wins over a software clear
  function automatic logic [7:0] micic_flag_upd
  (
    input logic [7:0] old_v,
    input logic [7:0] wd,
    input logic [7:0] wmask,
    input logic       wen,
    input logic [7:0] set_v
  );
    logic [7:0] v;
    v = old_v;
    if (wen)
    begin
      v = (old_v & ~wmask) | (wd & wmask);
    end
    micic_flag_upd = v | set_v;
  endfunction : micic_flag_upd

  // ==========================================================
  // state
  // ==========================================================
  logic [7:0]              ctrl;
  logic [7:0]              en [3];
  logic [7:0]              req [3];
  logic [7:0]              shadow [`MICIC_SHD_N];
  logic                    ext_prev;
  logic                    ioc_sum;
  micic_pkg::micic_state_t state;
  micic_pkg::micic_state_t next_state;

  // ==========================================================
  // address decode
  // ==========================================================
  wire logic                 hit_ctrl;
  wire logic [2:0]           hit_en;
  wire logic [2:0]           hit_req;
  wire logic [`MICIC_AW-1:0] shd_off;
  wire logic                 hit_shd;
  wire logic [2:0]           shd_idx;

  assign hit_ctrl = addr_in == `MICIC_ADR_CTRL;
  assign hit_en   = {addr_in == `MICIC_ADR_EN2, addr_in == `MICIC_ADR_EN1,
                     addr_in == `MICIC_ADR_EN0};
  assign hit_req  = {addr_in == `MICIC_ADR_REQ2, addr_in == `MICIC_ADR_REQ1,
                     addr_in == `MICIC_ADR_REQ0};
  assign shd_off  = addr_in - `MICIC_ADR_SHD_BASE;
  assign hit_shd  = (addr_in >= `MICIC_ADR_SHD_BASE) &&
                    (shd_off < `MICIC_AW'(`MICIC_SHD_N));
  assign shd_idx  = shd_off[2:0];

  // ==========================================================
  // events
  // ==========================================================
  wire logic       edge_sel;
  wire logic       ext_edge;
  wire logic [7:0] set0;
  wire logic [7:0] wmask [3];
  wire logic [7:0] set_v [3];
  wire logic [7:0] en_mask [3];

  assign edge_sel = ctrl[`MICIC_BIT_EDGE];
  // valid edge follows the edge select bit
  assign ext_edge = edge_sel ? (ext_pin_in & ~ext_prev)
                             : (~ext_pin_in & ext_prev);
  // flags set whatever the enables hold
  assign set0 = {2'h0, timer0_ovf_in, 4'h0, ext_edge};
  assign set_v[0] = set0;
  assign set_v[1] = req1_set_in;
  assign set_v[2] = req2_set_in;
  assign wmask[0] = `MICIC_REQ0_WMASK;
  assign wmask[1] = `MICIC_REQ1_WMASK;
  assign wmask[2] = `MICIC_REQ2_WMASK;
  assign en_mask[0] = `MICIC_EN0_MASK;
  assign en_mask[1] = 8'hff;
  assign en_mask[2] = `MICIC_EN2_MASK;

  // ==========================================================
  // qualification
  // ==========================================================
  wire logic [7:0] req0_view;
  wire logic       global_irq_enable;
  wire logic       peripheral_group_enable;
  wire logic       act0;
  wire logic       act12;
  wire logic       src_active;
  wire logic       vec_req;
  wire logic       take;
  wire logic       skip_q1;

  // summary flag is the or of per-port flags, read only
  assign req0_view = (req[0] & ~(8'h01 << `MICIC_BIT_IOC)) |
                     ({7'h00, ioc_sum} << `MICIC_BIT_IOC);
  assign global_irq_enable   = ctrl[`MICIC_BIT_GIE];
  assign peripheral_group_enable  = ctrl[`MICIC_BIT_PERIPHERAL_GROUP_ENABLE];
  // enable zero ignores the group enable
  assign act0  = |(req0_view & en[0]);
  assign act12 = peripheral_group_enable & (|(req[1] & en[1]) | |(req[2] & en[2]));
  assign src_active = act0 | act12;
  // single request gated by the global enable
  assign vec_req = global_irq_enable & src_active;
  assign skip_q1 = state == micic_pkg::MICIC_SKIP;
  // sampled only in q1, never in the skipped slot
  assign take    = q1_in & vec_req & ~skip_q1;

  // ==========================================================
  // context
  // ==========================================================
  wire logic [7:0] live [`MICIC_SHD_N];

  assign live[0] = working_register_in;
  assign live[1] = status_in & `MICIC_STATUS_KEEP;
  assign live[2] = bank_select_register_in;
  assign live[3] = fsr0_low_in;
  assign live[4] = fsr0_high_in;
  assign live[5] = fsr1_low_in;
  assign live[6] = fsr1_high_in;
  assign live[7] = pc_high_latch_in;

  // ==========================================================
  // read mux
  // ==========================================================
  wire logic [7:0] rd_mux;

  assign rd_mux = hit_ctrl   ? (ctrl & `MICIC_CTRL_MASK) :
                  hit_en[0]  ? en[0] :
                  hit_en[1]  ? en[1] :
                  hit_en[2]  ? en[2] :
                  hit_req[0] ? req0_view :
                  hit_req[1] ? req[1] :
                  hit_req[2] ? req[2] :
                  hit_shd    ? shadow[shd_idx] : 8'h00;

  // ==========================================================
  // sleep fsm
  // ==========================================================
  wire logic wake;

  // wake needs the source enables and, for banks 1 and 2, the group enable, not global
  assign wake = sleeping_in & src_active;

  always_comb
  begin
    next_state = state;
    unique case (state)
      micic_pkg::MICIC_RUN:
      begin
        if (wake)
        begin
          next_state = micic_pkg::MICIC_SKIP;
        end
      end
      micic_pkg::MICIC_SKIP:
      begin
        if (q1_in && !sleeping_in)
        begin
          next_state = micic_pkg::MICIC_RUN;
        end
      end
    endcase
  end

  // ==========================================================
  // registers
  // ==========================================================
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      ctrl <= `MICIC_CTRL_RST;
      state <= micic_pkg::MICIC_RUN;
      ext_prev <= ext_pin_in;
      ioc_sum <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ext_prev <= ext_pin_in;
      ioc_sum <= |per_port_change_flags_in;
      if (take)
      begin
        ctrl[`MICIC_BIT_GIE] <= 1'b0;
      end
      else if (return_from_interrupt_in)
      begin
        ctrl[`MICIC_BIT_GIE] <= 1'b1;
      end
      else if (wr_in && hit_ctrl)
      begin
        ctrl[`MICIC_BIT_GIE] <= wdata_in[`MICIC_BIT_GIE];
      end
      if (wr_in && hit_ctrl)
      begin
        ctrl[`MICIC_BIT_PERIPHERAL_GROUP_ENABLE] <= wdata_in[`MICIC_BIT_PERIPHERAL_GROUP_ENABLE];
        ctrl[`MICIC_BIT_EDGE] <= wdata_in[`MICIC_BIT_EDGE];
      end
    end
  end

  // enable and request registers, three of each
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_bank
      always_ff @(posedge clk_in)
      begin
        if (!rst_n_in)
        begin
          en[gi]  <= 8'h00;
          req[gi] <= 8'h00;
        end
        else
        begin
          if (wr_in && hit_en[gi])
          begin
            en[gi] <= wdata_in & en_mask[gi];
          end
          req[gi] <= micic_flag_upd(req[gi], wdata_in, wmask[gi],
                                    wr_in & hit_req[gi], set_v[gi]);
        end
      end
    end
  endgenerate

  // shadow registers: capture on entry, bus access otherwise
  generate
    for (gi = 0; gi < `MICIC_SHD_N; gi++)
    begin : g_shd
      // status shadow holds no watchdog-expiry or power-down bits
      localparam logic [7:0] shd_keep = (gi == 1) ? `MICIC_STATUS_KEEP : 8'hff;
      always_ff @(posedge clk_in)
      begin
        if (!rst_n_in)
        begin
          shadow[gi] <= 8'h00;
        end
        else if (take)
        begin
          shadow[gi] <= live[gi];
        end
        else if (wr_in && hit_shd && shd_idx == 3'(gi))
        begin
          shadow[gi] <= wdata_in & shd_keep;
        end
      end
    end
  endgenerate

  // ==========================================================
  // outputs
  // ==========================================================
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      rdata_out <= 8'h00;
      vector_out <= 1'b0;
      vector_addr_out <= `MICIC_VECTOR;
      restore_out <= 1'b0;
      wake_out <= 1'b0;
    end
    else
    begin
      rdata_out <= rd_in ? rd_mux : 8'h00;
      vector_out <= take;
      vector_addr_out <= `MICIC_VECTOR;
      restore_out <= return_from_interrupt_in;
      wake_out <= wake;
    end
  end

  // restored context is the shadow content itself
  assign working_register_out     = shadow[0];
  assign status_out               = shadow[1];
  assign bank_select_register_out = shadow[2];
  assign fsr0_low_out             = shadow[3];
  assign fsr0_high_out            = shadow[4];
  assign fsr1_low_out             = shadow[5];
  assign fsr1_high_out            = shadow[6];
  assign pc_high_latch_out        = shadow[7];

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_reset_disables: assert property ($rose(rst_n_in) |-> !global_irq_enable && !vector_out)
    else $error("enables not clear after reset");
  a_vector_needs_gie: assert property (vector_out |-> $past(global_irq_enable) && $past(q1_in))
    else $error("vector without global enable in q1");
  a_vector_clears_gie: assert property (vector_out |-> !global_irq_enable)
    else $error("global enable not cleared on vector");
  a_no_vec_gie_off: assert property (!global_irq_enable |=> !vector_out)
    else $error("vector while global enable clear");
  a_return_sets_gie: assert property (return_from_interrupt_in && !take
                                       |=> global_irq_enable && restore_out)
    else $error("return did not set global enable");
  a_restore_pulse: assert property (return_from_interrupt_in |=> restore_out)
    else $error("restore pulse missing");
  a_vector_q1_only: assert property (!q1_in |=> !vector_out)
    else $error("vector outside q1 sample");
  a_rise_edge_flag: assert property (edge_sel && ext_pin_in && !ext_prev
                                      |=> req[0][`MICIC_BIT_EXT])
    else $error("rising edge lost");
  a_fall_edge_flag: assert property (!edge_sel && !ext_pin_in && ext_prev
                                      |=> req[0][`MICIC_BIT_EXT])
    else $error("falling edge lost");
  a_timer_flag_set: assert property (timer0_ovf_in |=> req[0][`MICIC_BIT_TMR0])
    else $error("timer flag lost");
  a_save_status: assert property (take
                                  |=> shadow[1] == ($past(status_in) & `MICIC_STATUS_KEEP))
    else $error("status not saved");
  a_shadow_write: assert property (wr_in && hit_shd && !take && shd_idx == 3'h0
                                   |=> working_register_out == $past(wdata_in))
    else $error("shadow write lost");
  a_group_gate: assert property (vector_out && !$past(act0) |-> $past(peripheral_group_enable))
    else $error("group source vectored without group enable");
  a_skip_after_wake: assert property (wake_out |-> !vector_out ##1 !vector_out)
    else $error("vector straight after wake");
  a_wake_follows: assert property (sleeping_in && src_active |=> wake_out)
    else $error("no wake on enabled flag");

  c_vector: cover property (vector_out);
  c_return: cover property (restore_out ##[1:20] vector_out);
  c_wake: cover property (wake_out ##[1:40] vector_out);
  c_pending_gie: cover property (!global_irq_enable && src_active ##[1:20] vector_out);
  c_group_vec: cover property (vector_out && !$past(act0));

endmodule : micic_top

/* File: verification/micic_core_model.sv */
// core model: q1 timing and live context reloaded on restore
`timescale 1ns/1ps
module micic_core_model
#(
  parameter logic [63:0] INIT = 64'h0123456789abcdef
)
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        sleep_in,
  input  wire logic        bump_in,
  input  wire logic        restore_in,
  input  wire logic [63:0] shadow_in,
  output logic             q1_out,
  output logic      [63:0] live_out
);
  logic [1:0] phase;
  // ==========================================
  // instruction phases, q1 masked in sleep while the phase counter keeps running
  assign q1_out = (phase == 2'h0) && !sleep_in;
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      phase    <= 2'h0;
      live_out <= INIT;
    end
    else
    begin
      phase <= phase + 2'h1;
      if (restore_in)
        live_out <= shadow_in;
      else if (bump_in)
        live_out <= live_out + 64'h0101010101010101;
    end
  end
endmodule : micic_core_model

/* File: verification/tb.sv */
// testbench: register model, vectoring, context and sleep checks
`timescale 1ns/1ps
`include "micic_defs.svh"
module tb;
  localparam logic [63:0] KEEP = {8'hff, `MICIC_STATUS_KEEP, 48'hffffffffffff};
  logic                 clk_in, rst_n_in, wr_in, rd_in, ext_pin_in, timer0_ovf_in;
  logic                 return_from_interrupt_in, sleeping_in, bump, hit;
  logic [`MICIC_AW-1:0] addr_in;
  logic [7:0]           wdata_in, req1_set_in, req2_set_in, b, rdata_out;
  logic [2:0]           per_port_change_flags_in;
  logic [7:0]           working_register_in, status_in, bank_select_register_in, fsr0_low_in;
  logic [7:0]           fsr0_high_in, fsr1_low_in, fsr1_high_in, pc_high_latch_in;
  logic [7:0]           working_register_out, status_out, bank_select_register_out;
  logic [7:0]           fsr0_low_out, fsr0_high_out, fsr1_low_out, fsr1_high_out;
  logic [7:0]           pc_high_latch_out;
  logic                 q1_in, vector_out, restore_out, wake_out;
  logic [14:0]          vector_addr_out;
  logic [63:0]          live, shd;
  int                   errors, compares, seed, k, fa;
  int                   mdl[int], msk[int];
  assign {working_register_in, status_in, bank_select_register_in, fsr0_low_in, fsr0_high_in,
          fsr1_low_in, fsr1_high_in, pc_high_latch_in} = live;
  assign shd = {working_register_out, status_out, bank_select_register_out, fsr0_low_out,
                fsr0_high_out, fsr1_low_out, fsr1_high_out, pc_high_latch_out};
  micic_top i_dut
  (
    .clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .q1_in, .ext_pin_in,
    .timer0_ovf_in, .per_port_change_flags_in, .req1_set_in, .req2_set_in,
    .return_from_interrupt_in, .sleeping_in, .working_register_in, .status_in,
    .bank_select_register_in, .fsr0_low_in, .fsr0_high_in, .fsr1_low_in, .fsr1_high_in,
    .pc_high_latch_in, .vector_out, .vector_addr_out, .restore_out, .wake_out,
    .working_register_out, .status_out, .bank_select_register_out, .fsr0_low_out,
    .fsr0_high_out, .fsr1_low_out, .fsr1_high_out, .pc_high_latch_out
  );
  micic_core_model i_core
  (
    .clk_in, .rst_n_in, .sleep_in(sleeping_in), .bump_in(bump), .restore_in(restore_out),
    .shadow_in(shd), .q1_out(q1_in), .live_out(live)
  );
  // ==========================================
  // compare, bus and event tasks
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_reg
  task automatic chk_sig(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %b", $time, what, got);
    end
  endtask : chk_sig
  task automatic init_mdl;
    foreach (msk[a])
      mdl[a] = 0;
    mdl[`MICIC_ADR_CTRL] = `MICIC_CTRL_RST;
  endtask : init_mdl
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    if (msk.exists(a))
      mdl[a] = (mdl[a] & ~msk[a]) | (d & msk[a]);
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [12:0] a);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk_reg(rdata_out, mdl.exists(a) ? 8'(mdl[a]) : 8'h00, "read");
  endtask : rd
  task automatic wait_vec(input int n, input logic exp);
    hit = 1'b0;
    repeat (n)
    begin
      @(posedge clk_in);
      #1;
      if (vector_out === 1'b1)
      begin
        hit = 1'b1;
        mdl[`MICIC_ADR_CTRL] &= 8'h7f;
        for (int i = 0; i < 8; i++)
          mdl[`MICIC_ADR_SHD_BASE + i] = live[63 - 8*i -: 8] & KEEP[63 - 8*i -: 8];
        chk_sig(vector_addr_out === `MICIC_VECTOR, 1'b1, "addr");
      end
    end
    chk_sig(hit, exp, "vector");
  endtask : wait_vec
  task automatic ret;
    @(posedge clk_in);
    return_from_interrupt_in <= 1'b1;
    @(posedge clk_in);
    return_from_interrupt_in <= 1'b0;
    #1;
    chk_sig(restore_out, 1'b1, "restore");
    mdl[`MICIC_ADR_CTRL] |= 8'h80;
    @(posedge clk_in);
    #1;
    for (int i = 0; i < 8; i++)
      chk_reg(live[63 - 8*i -: 8], 8'(mdl[`MICIC_ADR_SHD_BASE + i]), "context");
  endtask : ret
  task automatic fire(input int j, input logic [7:0] v);
    @(posedge clk_in);
    timer0_ovf_in <= (j == 0);
    req1_set_in <= (j == 1) ? v : 8'h00;
    req2_set_in <= (j == 2) ? v : 8'h00;
    @(posedge clk_in);
    timer0_ovf_in <= 1'b0;
    req1_set_in <= 8'h00;
    req2_set_in <= 8'h00;
  endtask : fire
  task automatic pin(input logic v);
    @(posedge clk_in);
    ext_pin_in <= v;
    repeat (2) @(posedge clk_in);
  endtask : pin
  task automatic close_out;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial
  begin
    repeat (20000) @(posedge clk_in);
    errors++;
    close_out;
  end
  // ==========================================
  // main sequence
  initial
  begin
    seed = 32'h4d46;
    {rst_n_in, wr_in, rd_in, ext_pin_in, timer0_ovf_in, return_from_interrupt_in} = '0;
    {sleeping_in, bump, addr_in, wdata_in, req1_set_in, req2_set_in} = '0;
    per_port_change_flags_in = 3'h0;
    msk[`MICIC_ADR_CTRL] = `MICIC_CTRL_MASK;
    msk[`MICIC_ADR_REQ0] = `MICIC_REQ0_WMASK;
    msk[`MICIC_ADR_REQ1] = `MICIC_REQ1_WMASK;
    msk[`MICIC_ADR_REQ2] = `MICIC_REQ2_WMASK;
    msk[`MICIC_ADR_EN0] = `MICIC_EN0_MASK;
    msk[`MICIC_ADR_EN1] = 8'hff;
    msk[`MICIC_ADR_EN2] = `MICIC_EN2_MASK;
    for (int i = 0; i < 8; i++)
      msk[`MICIC_ADR_SHD_BASE + i] = (i == 1) ? `MICIC_STATUS_KEEP : 8'hff;
    init_mdl;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    foreach (msk[a])
      rd(13'(a));
    rd(13'h0100);
    foreach (msk[a])
    begin
      wr(13'(a), 8'($random(seed)) & ((a == `MICIC_ADR_CTRL) ? 8'h7f : 8'hff));
      rd(13'(a));
    end
    foreach (msk[a])
      wr(13'(a), 8'h00);
    wr(`MICIC_ADR_EN0, 8'h01);
    for (int e = 1; e >= 0; e--)
    begin
      wr(`MICIC_ADR_CTRL, 8'(e));
      pin(e);
      wr(`MICIC_ADR_REQ0, 8'h00);
      pin(!e);
      rd(`MICIC_ADR_REQ0);
      pin(e);
      mdl[`MICIC_ADR_REQ0] |= 1;
      rd(`MICIC_ADR_REQ0);
      wait_vec(8, 1'b0);
    end
    wr(`MICIC_ADR_CTRL, 8'h80);
    wait_vec(8, 1'b1);
    rd(`MICIC_ADR_CTRL);
    for (int i = 0; i < 8; i++)
      rd(13'(`MICIC_ADR_SHD_BASE + i));
    @(posedge clk_in);
    bump <= 1'b1;
    @(posedge clk_in);
    bump <= 1'b0;
    wr(`MICIC_ADR_SHD_BASE, 8'($random(seed)));
    wr(`MICIC_ADR_REQ0, 8'h00);
    ret;
    wait_vec(8, 1'b0);
    wr(`MICIC_ADR_EN0, 8'h20);
    wr(`MICIC_ADR_EN1, 8'hff);
    wr(`MICIC_ADR_EN2, 8'he0);
    for (int j = 0; j < 3; j++)
    begin
      k = $unsigned($random(seed)) % 3;
      b = (j == 0) ? 8'h20 : (j == 1) ? 8'h01 << k : 8'h20 << k;
      fa = `MICIC_ADR_REQ0 + j;
      wr(`MICIC_ADR_CTRL, 8'h80);
      fire(j, b);
      mdl[fa] |= b;
      wait_vec(8, j == 0);
      if (j > 0)
      begin
        wr(`MICIC_ADR_CTRL, 8'hc0);
        wait_vec(8, 1'b1);
      end
      rd(13'(fa));
      wr(13'(fa), 8'h00);
      ret;
    end
    @(posedge clk_in);
    per_port_change_flags_in <= 3'($random(seed)) | 3'h1;
    repeat (2) @(posedge clk_in);
    mdl[`MICIC_ADR_REQ0] = 8'h10;
    wr(`MICIC_ADR_REQ0, 8'h00);
    rd(`MICIC_ADR_REQ0);
    @(posedge clk_in);
    per_port_change_flags_in <= 3'h0;
    repeat (2) @(posedge clk_in);
    mdl[`MICIC_ADR_REQ0] = 0;
    rd(`MICIC_ADR_REQ0);
    for (int g = 0; g < 2; g++)
    begin
      wr(`MICIC_ADR_CTRL, (g == 1) ? 8'h80 : 8'h00);
      @(posedge clk_in);
      sleeping_in <= 1'b1;
      fire(0, 8'h20);
      mdl[`MICIC_ADR_REQ0] |= 8'h20;
      @(posedge clk_in);
      #1;
      chk_sig(wake_out, 1'b1, "wake");
      @(posedge clk_in);
      sleeping_in <= 1'b0;
      #1;
      k = 0;
      while (q1_in !== 1'b1 && k < 8)
      begin
        @(posedge clk_in);
        #1;
        k++;
      end
      wait_vec(4, 1'b0);
      wait_vec(4, g == 1);
      wr(`MICIC_ADR_REQ0, 8'h00);
      if (g == 1)
        ret;
    end
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    init_mdl;
    foreach (msk[a])
      rd(13'(a));
    close_out;
  end
endmodule : tb
